// ===== rtl/dcc_regs.svh
// Register addresses, write masks, reset values and bit positions of the comparator control bank
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// Special-function register addresses
`define DCC_ADDR_CMP1_CTRL 8'h9A
`define DCC_ADDR_CMP0_CTRL 8'h9B
`define DCC_ADDR_CMP0_MODE 8'h9D
`define DCC_ADDR_CMP0_MUX 8'h9F

// Reset values
`define DCC_CTRL_RESET 8'h00
`define DCC_MODE_RESET 8'h02
`define DCC_MUX_RESET 8'h00

// Writable bits; everything else is read-only or unused
`define DCC_CTRL_WMASK 8'hBF
`define DCC_MODE_WMASK 8'h33
`define DCC_MUX_WMASK 8'h77

// Bit positions inside the control registers
`define DCC_CTRL_EN_BIT 7
`define DCC_CTRL_OUT_BIT 6
`define DCC_CTRL_RISE_BIT 5
`define DCC_CTRL_FALL_BIT 4

// Value returned for an unmapped address
`define DCC_RDATA_UNMAPPED 8'h00

// Highest legal multiplexer select code
`define DCC_MUX_MAX_CODE 3'h4

// Pin code for an undefined multiplexer select
`define DCC_PIN_NONE 8'hFF

`endif

// ===== rtl/dcc_pkg.sv
// Types shared by the comparator control bank
package dcc_pkg;

    // Hysteresis setting sent to the analog comparator
    typedef enum logic [1:0] {
        DCC_HYST_OFF = 2'h0,
        DCC_HYST_5MV = 2'h1,
        DCC_HYST_10MV = 2'h2,
        DCC_HYST_20MV = 2'h3
    } dcc_hyst_t;

    // Response-time and power trade-off
    typedef enum logic [1:0] {
        DCC_RESP_FASTEST = 2'h0,
        DCC_RESP_MID1 = 2'h1,
        DCC_RESP_MID2 = 2'h2,
        DCC_RESP_LOWPOWER = 2'h3
    } dcc_resp_t;

    // Control register, laid out bit for bit as software sees it
    typedef struct packed {
        logic enable;
        logic out_pad;
        logic rise_flag;
        logic fall_flag;
        dcc_hyst_t pos_hyst;
        dcc_hyst_t neg_hyst;
    } dcc_ctrl_t;

    // Mode register layout
    typedef struct packed {
        logic [1:0] pad_hi;
        logic rise_irq_en;
        logic fall_irq_en;
        logic [1:0] pad_lo;
        dcc_resp_t resp;
    } dcc_mode_t;

    // Input multiplexer register layout
    typedef struct packed {
        logic pad_hi;
        logic [2:0] neg_sel;
        logic pad_lo;
        logic [2:0] pos_sel;
    } dcc_mux_t;

    // Settings driven to one analog comparator
    typedef struct packed {
        logic enable;
        dcc_hyst_t pos_hyst;
        dcc_hyst_t neg_hyst;
    } dcc_cmp_cfg_t;

    // Port pin picked by the multiplexer: port number and bit number
    typedef struct packed {
        logic [3:0] port_num;
        logic [3:0] bit_num;
    } dcc_pin_t;

endpackage

// ===== rtl/dcc_cmp_sync.sv
// Synchroniser and edge detector for one asynchronous comparator output
`timescale 1ns/10ps
module dcc_cmp_sync
(
    input wire logic core_clk_in, // System clock
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic raw_in, // Raw comparator result, asynchronous
    input wire logic enable_in, // Comparator enable from the control register
    output logic level_out, // Synchronised result, low while disabled
    output logic rise_out, // One-cycle pulse on a low-to-high change
    output logic fall_out // One-cycle pulse on a high-to-low change
);
    import dcc_pkg::*;

    // All state of this module
    typedef struct packed {
        logic meta; // First stage, read only by the second
        logic stable; // Second stage
        logic level; // Gated level seen last cycle
        logic rise;
        logic fall;
    } dcc_sync_state_t;

    dcc_sync_state_t st_reg; // Registered state
    dcc_sync_state_t st_next; // Next state
    logic gated; // Result forced low while disabled

    // Edges come from the gated level, so a disabled comparator is quiet after one fall pulse if its level was high
    always_comb
    begin
        st_next = st_reg;
        gated = st_reg.stable & enable_in;
        st_next.meta = raw_in; // R19
        st_next.stable = st_reg.meta; // R19
        st_next.level = gated; // R17
        st_next.rise = gated & ~st_reg.level;
        st_next.fall = ~gated & st_reg.level;
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;
    assign rise_out = st_reg.rise;
    assign fall_out = st_reg.fall;

endmodule

// ===== rtl/dcc_top.sv
// Control and status register bank for the two on-chip comparators
//
// Notes on behaviour
// R01: Enable bit powers comparator 0 on or off
// R02: Output-state bit shows result, ignores writes
// R03: Rising edge sets sticky rise flag
// R04: Falling edge sets sticky fall flag
// R05: Flags clear only by software writing zero
// R06: Positive hysteresis code drives analog setting
// R07: Negative hysteresis code uses same encoding
// R08: Negative select routes one of five pins
// R09: Positive select routes one of five pins
// R10: Pin table depends on package variant
// R11: Unused multiplexer bits read zero
// R12: Unused mode bits read zero
// R13: Mode bit enables rising-edge interrupt
// R14: Mode bit enables falling-edge interrupt
// R15: Response-mode field drives analog speed
// R16: Comparator 1 control register, same layout
// R17: Disabled comparator output held low
// R18: Interrupt while enabled flag is set
// R19: Two-stage synchroniser before edge detection
// R20: Edge set wins over same-cycle clear
`timescale 1ns/10ps
`include "dcc_regs.svh"
module dcc_top
#(
    parameter bit PKG_48PIN = 1'b0 // Package variant: 0 for 32 pins, 1 for 48
)
(
    input wire logic core_clk_in, // System clock, 50 MHz
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic sfr_wr_in, // Write strobe, one cycle
    input wire logic sfr_rd_in, // Read strobe, one cycle
    input wire logic [7:0] sfr_wdata_in, // Write data
    output logic [7:0] sfr_rdata_out, // Read data, valid the cycle after the strobe
    input wire logic cmp0_raw_in, // Comparator 0 raw result
    input wire logic cmp1_raw_in, // Comparator 1 raw result
    output dcc_pkg::dcc_cmp_cfg_t cmp0_cfg_out, // Comparator 0 analog settings
    output dcc_pkg::dcc_cmp_cfg_t cmp1_cfg_out, // Comparator 1 analog settings
    output dcc_pkg::dcc_resp_t cmp0_resp_out, // Comparator 0 response mode
    output dcc_pkg::dcc_pin_t cmp0_pos_pin_out, // Pin on the positive input
    output dcc_pkg::dcc_pin_t cmp0_neg_pin_out, // Pin on the negative input
    output logic cmp0_latched_out, // Synchronous output toward the pins
    output logic cmp1_latched_out, // Synchronous output toward the pins
    output logic cmp0_irq_out // Comparator 0 interrupt request, level
);
    import dcc_pkg::*;

    // All state of the bank
    typedef struct packed {
        dcc_ctrl_t ctrl0; // Comparator 0 control
        dcc_ctrl_t ctrl1; // Comparator 1 control
        dcc_mode_t mode0; // Comparator 0 mode
        dcc_mux_t mux0; // Comparator 0 input selects
        dcc_pin_t pos_pin; // Decoded positive pin
        dcc_pin_t neg_pin; // Decoded negative pin
        logic irq; // Interrupt request
        logic [7:0] rdata; // Read data holding register
    } dcc_state_t;

    dcc_state_t st_reg; // Registered state
    dcc_state_t st_next; // Next state

    // Synchroniser outputs
    logic level0; // Comparator 0 gated level
    logic level1; // Comparator 1 gated level
    logic rise0; // Comparator 0 rising pulse
    logic fall0; // Comparator 0 falling pulse
    logic rise1; // Comparator 1 rising pulse
    logic fall1; // Comparator 1 falling pulse

    // Address decode
    logic wr_ctrl0; // Write to comparator 0 control
    logic wr_ctrl1; // Write to comparator 1 control
    logic wr_mode0; // Write to comparator 0 mode
    logic wr_mux0; // Write to comparator 0 multiplexer

    // Comparator 0 synchroniser and edge detector
    dcc_cmp_sync u_sync0
    (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .raw_in(cmp0_raw_in),
        .enable_in(st_reg.ctrl0.enable),
        .level_out(level0),
        .rise_out(rise0),
        .fall_out(fall0)
    );

    // Comparator 1 uses the same detector
    dcc_cmp_sync u_sync1
    (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .raw_in(cmp1_raw_in),
        .enable_in(st_reg.ctrl1.enable),
        .level_out(level1),
        .rise_out(rise1),
        .fall_out(fall1)
    );

    // Apply a software write and hardware edges to one control register.
    // The flag set term is ORed after the write so an edge in the same
    // cycle as a clearing write survives.
    function automatic dcc_ctrl_t ctrl_update
    (
        input dcc_ctrl_t cur,
        input logic wr,
        input logic [7:0] wdata,
        input logic rise,
        input logic fall
    );
        dcc_ctrl_t nxt;
        nxt = cur;
        if (wr)
        begin
            // Output-state position is read-only and stays zero in storage
            nxt = dcc_ctrl_t'(wdata & `DCC_CTRL_WMASK); // R01 R02 R06 R07 R16
        end
        // Hardware only ever sets; clearing is software's job
        nxt.rise_flag = nxt.rise_flag | rise; // R03 R05 R20
        nxt.fall_flag = nxt.fall_flag | fall; // R04 R05 R20
        return nxt;
    endfunction

    // Build the read value of a control register with its live level
    function automatic logic [7:0] ctrl_read
    (
        input dcc_ctrl_t cur,
        input logic level
    );
        logic [7:0] val;
        val = cur;
        val[`DCC_CTRL_OUT_BIT] = level; // R02
        return val;
    endfunction

    // Map a select code to a port pin; codes above four map to no pin.
    // The two packages bring different pins out, so the table is per variant.
    function automatic dcc_pin_t pin_lookup
    (
        input logic [2:0] code,
        input logic is_neg
    );
        dcc_pin_t pin;
        pin = dcc_pin_t'(`DCC_PIN_NONE);
        if (!PKG_48PIN)
        begin
            // 32-pin package
            case (code)
                3'h0: pin = is_neg ? dcc_pin_t'(8'h11) : dcc_pin_t'(8'h10);
                3'h1: pin = is_neg ? dcc_pin_t'(8'h15) : dcc_pin_t'(8'h14);
                3'h2: pin = is_neg ? dcc_pin_t'(8'h21) : dcc_pin_t'(8'h20);
                3'h3: pin = is_neg ? dcc_pin_t'(8'h25) : dcc_pin_t'(8'h24);
                3'h4: pin = is_neg ? dcc_pin_t'(8'h01) : dcc_pin_t'(8'h00);
                default: pin = dcc_pin_t'(`DCC_PIN_NONE);
            endcase
        end
        else
        begin
            // 48-pin package
            case (code)
                3'h0: pin = is_neg ? dcc_pin_t'(8'h21) : dcc_pin_t'(8'h20);
                3'h1: pin = is_neg ? dcc_pin_t'(8'h26) : dcc_pin_t'(8'h25);
                3'h2: pin = is_neg ? dcc_pin_t'(8'h35) : dcc_pin_t'(8'h34);
                3'h3: pin = is_neg ? dcc_pin_t'(8'h44) : dcc_pin_t'(8'h43);
                3'h4: pin = is_neg ? dcc_pin_t'(8'h04) : dcc_pin_t'(8'h03);
                default: pin = dcc_pin_t'(`DCC_PIN_NONE);
            endcase
        end
        return pin;
    endfunction

    // Write decode; reads have no side effects
    assign wr_ctrl0 = sfr_wr_in && (sfr_addr_in == `DCC_ADDR_CMP0_CTRL);
    assign wr_ctrl1 = sfr_wr_in && (sfr_addr_in == `DCC_ADDR_CMP1_CTRL);
    assign wr_mode0 = sfr_wr_in && (sfr_addr_in == `DCC_ADDR_CMP0_MODE);
    assign wr_mux0 = sfr_wr_in && (sfr_addr_in == `DCC_ADDR_CMP0_MUX);

    // Next-state logic for the whole bank
    always_comb
    begin
        st_next = st_reg;

        // Control registers with sticky edge flags
        st_next.ctrl0 = ctrl_update(st_reg.ctrl0, wr_ctrl0, sfr_wdata_in, rise0, fall0);
        st_next.ctrl1 = ctrl_update(st_reg.ctrl1, wr_ctrl1, sfr_wdata_in, rise1, fall1); // R16

        // Mode register; unused bits are masked so they stay zero
        if (wr_mode0)
        begin
            st_next.mode0 = dcc_mode_t'(sfr_wdata_in & `DCC_MODE_WMASK); // R12 R13 R14 R15
        end

        // Multiplexer register; unused bits are masked so they stay zero
        if (wr_mux0)
        begin
            st_next.mux0 = dcc_mux_t'(sfr_wdata_in & `DCC_MUX_WMASK); // R11 R08 R09
        end

        // Pin decode follows the stored selects one cycle later
        st_next.pos_pin = pin_lookup(st_reg.mux0.pos_sel, 1'b0); // R09 R10
        st_next.neg_pin = pin_lookup(st_reg.mux0.neg_sel, 1'b1); // R08 R10

        // Level request from the registered flags and enables; it
        // drops the cycle after software clears the flag or the enable
        st_next.irq = (st_reg.ctrl0.rise_flag & st_reg.mode0.rise_irq_en) // R18 R13
            | (st_reg.ctrl0.fall_flag & st_reg.mode0.fall_irq_en); // R18 R14

        // Read data is captured on the strobe and then held
        if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                `DCC_ADDR_CMP0_CTRL: st_next.rdata = ctrl_read(st_reg.ctrl0, level0); // R02
                `DCC_ADDR_CMP1_CTRL: st_next.rdata = ctrl_read(st_reg.ctrl1, level1); // R16
                `DCC_ADDR_CMP0_MODE: st_next.rdata = st_reg.mode0; // R12
                `DCC_ADDR_CMP0_MUX: st_next.rdata = st_reg.mux0; // R11
                default: st_next.rdata = `DCC_RDATA_UNMAPPED;
            endcase
        end
    end

    // State register; reset values are constants only
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg.ctrl0 <= dcc_ctrl_t'(`DCC_CTRL_RESET);
            st_reg.ctrl1 <= dcc_ctrl_t'(`DCC_CTRL_RESET);
            st_reg.mode0 <= dcc_mode_t'(`DCC_MODE_RESET);
            st_reg.mux0 <= dcc_mux_t'(`DCC_MUX_RESET);
            // Pin decode of select code zero so outputs agree with the mux
            st_reg.pos_pin <= PKG_48PIN ? dcc_pin_t'(8'h20) : dcc_pin_t'(8'h10);
            st_reg.neg_pin <= PKG_48PIN ? dcc_pin_t'(8'h21) : dcc_pin_t'(8'h11);
            st_reg.irq <= 1'b0;
            st_reg.rdata <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Analog settings come straight from the stored fields
    assign cmp0_cfg_out.enable = st_reg.ctrl0.enable; // R01
    assign cmp0_cfg_out.pos_hyst = st_reg.ctrl0.pos_hyst; // R06
    assign cmp0_cfg_out.neg_hyst = st_reg.ctrl0.neg_hyst; // R07
    assign cmp1_cfg_out.enable = st_reg.ctrl1.enable; // R16
    assign cmp1_cfg_out.pos_hyst = st_reg.ctrl1.pos_hyst; // R16
    assign cmp1_cfg_out.neg_hyst = st_reg.ctrl1.neg_hyst; // R16
    assign cmp0_resp_out = st_reg.mode0.resp; // R15
    assign cmp0_pos_pin_out = st_reg.pos_pin;
    assign cmp0_neg_pin_out = st_reg.neg_pin;

    // Latched outputs are already low while disabled
    assign cmp0_latched_out = level0; // R17
    assign cmp1_latched_out = level1; // R17
    assign cmp0_irq_out = st_reg.irq;
    assign sfr_rdata_out = st_reg.rdata;

endmodule

// ===== testbench/dcc_top_checker.sv
// Concurrent checks on the ports of the comparator control bank
`timescale 1ns/10ps
module dcc_top_checker
import dcc_pkg::*;
#(
    parameter bit PKG_48PIN = 1'b0 // Package variant
)
(
    input wire logic core_clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic [7:0] sfr_addr_in, // Address
    input wire logic sfr_wr_in, // Write strobe
    input wire logic sfr_rd_in, // Read strobe
    input wire logic [7:0] sfr_wdata_in, // Write data
    input wire logic [7:0] sfr_rdata_out, // Read data
    input wire logic cmp0_raw_in, // Raw result 0
    input wire logic cmp1_raw_in, // Raw result 1
    input wire dcc_cmp_cfg_t cmp0_cfg_out, // Settings 0
    input wire dcc_cmp_cfg_t cmp1_cfg_out, // Settings 1
    input wire dcc_resp_t cmp0_resp_out, // Response mode
    input wire dcc_pin_t cmp0_pos_pin_out, // Positive pin
    input wire dcc_pin_t cmp0_neg_pin_out, // Negative pin
    input wire logic cmp0_latched_out, // Output 0
    input wire logic cmp1_latched_out, // Output 1
    input wire logic cmp0_irq_out // Interrupt
);
    // Pin codes {port,bit}, positive inputs first, then negative
    localparam logic [7:0] PIN32 [0:9] = '{8'h10, 8'h14, 8'h20, 8'h24, 8'h00,
        8'h11, 8'h15, 8'h21, 8'h25, 8'h01};
    localparam logic [7:0] PIN48 [0:9] = '{8'h20, 8'h25, 8'h34, 8'h43, 8'h03,
        8'h21, 8'h26, 8'h35, 8'h44, 8'h04};
    logic wr0, wr1, wrm, wrx, rdc, rdm, rdx; // Decoded strobes
    assign wr0 = sfr_wr_in && sfr_addr_in == 8'h9B;
    assign wr1 = sfr_wr_in && sfr_addr_in == 8'h9A;
    assign wrm = sfr_wr_in && sfr_addr_in == 8'h9D;
    assign wrx = sfr_wr_in && sfr_addr_in == 8'h9F;
    assign rdc = sfr_rd_in && sfr_addr_in == 8'h9B;
    assign rdm = sfr_rd_in && sfr_addr_in == 8'h9D;
    assign rdx = sfr_rd_in && sfr_addr_in == 8'h9F;
    // Codes above four pick no pin at all
    function automatic logic [7:0] pin_exp(input logic [2:0] c, input logic n);
        if (c > 3'h4)
            return 8'hFF;
        return PKG_48PIN ? PIN48[n * 5 + c] : PIN32[n * 5 + c];
    endfunction
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    cmp0_cfg_a: assert property (wr0 |=> cmp0_cfg_out ==
        {$past(sfr_wdata_in[7]), $past(sfr_wdata_in[3:0])}) else $error("cmp0 settings wrong");
    cmp1_cfg_a: assert property (wr1 |=> cmp1_cfg_out ==
        {$past(sfr_wdata_in[7]), $past(sfr_wdata_in[3:0])}) else $error("cmp1 settings wrong");
    resp_mode_a: assert property (wrm |=> cmp0_resp_out == $past(sfr_wdata_in[1:0]))
        else $error("response mode wrong");
    pin_map_a: assert property (wrx |-> ##2
        cmp0_pos_pin_out == pin_exp($past(sfr_wdata_in[2:0], 2), 1'b0) &&
        cmp0_neg_pin_out == pin_exp($past(sfr_wdata_in[6:4], 2), 1'b1)) else $error("pin wrong");
    mux_pad_a: assert property (rdx |=> !sfr_rdata_out[7] && !sfr_rdata_out[3])
        else $error("mux spare bits set");
    mode_pad_a: assert property (rdm |=> (sfr_rdata_out & 8'hCC) == 8'h00)
        else $error("mode spare bits set");
    out_bit_a: assert property (rdc |=> sfr_rdata_out[6] == $past(cmp0_latched_out))
        else $error("output bit wrong");
    off_low_a: assert property ((!cmp0_cfg_out.enable)[*2] |-> !cmp0_latched_out)
        else $error("output high while off");
    sync_depth_a: assert property ($rose(cmp0_latched_out) |-> $past(cmp0_raw_in, 3))
        else $error("output rose too early");
    irq_cause_a: assert property ($rose(cmp0_irq_out) |-> $past(sfr_wr_in, 2) ||
        $past(cmp0_latched_out, 2) != $past(cmp0_latched_out, 3)) else $error("irq no cause");
    cover property ($rose(cmp0_irq_out));
    cover property ($fell(cmp0_latched_out));
    cover property (wrx);
endmodule
bind dcc_top dcc_top_checker #(.PKG_48PIN(PKG_48PIN)) i_dcc_top_checker (.core_clk_in,
    .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .cmp0_raw_in, .cmp1_raw_in, .cmp0_cfg_out, .cmp1_cfg_out, .cmp0_resp_out,
    .cmp0_pos_pin_out, .cmp0_neg_pin_out, .cmp0_latched_out, .cmp1_latched_out,
    .cmp0_irq_out);

// ===== testbench/dcc_top_tb.sv
// Self-checking testbench for the comparator control bank
`timescale 1ns/10ps
module dcc_top_tb;
    import dcc_pkg::*;
    localparam logic [7:0] PIN32 [0:9] = '{8'h10, 8'h14, 8'h20, 8'h24, 8'h00,
        8'h11, 8'h15, 8'h21, 8'h25, 8'h01};
    logic core_clk_in = 1'b0; // System clock
    logic rst_n_in = 1'b0; // Reset, active low
    logic [7:0] sfr_addr = 8'h00; // Bus address
    logic sfr_wr = 1'b0; // Write strobe
    logic sfr_rd = 1'b0; // Read strobe
    logic [7:0] sfr_wdata = 8'h00; // Write data
    logic raw0 = 1'b0; // Comparator 0 result
    logic raw1 = 1'b0; // Comparator 1 result
    logic [7:0] rdata; // Read data
    dcc_cmp_cfg_t cfg0, cfg1; // Settings
    dcc_resp_t resp; // Response mode
    dcc_pin_t pos_pin, neg_pin; // Picked pins
    logic lat0, lat1, irq; // Outputs
    int num_errors = 0; // Mismatches
    int checks = 0; // Comparisons
    dcc_top #(.PKG_48PIN(1'b0)) i_dcc_top (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
        .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(rdata), .cmp0_raw_in(raw0),
        .cmp1_raw_in(raw1), .cmp0_cfg_out(cfg0), .cmp1_cfg_out(cfg1), .cmp0_resp_out(resp),
        .cmp0_pos_pin_out(pos_pin), .cmp0_neg_pin_out(neg_pin), .cmp0_latched_out(lat0),
        .cmp1_latched_out(lat1), .cmp0_irq_out(irq));
    // Clock at 50 MHz
    initial
    begin
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitn(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // Bus cycles: inputs move on the falling edge, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk_in);
        sfr_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_in);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk_in);
        sfr_rd = 1'b0;
        chk(rdata, exp);
    endtask
    // Reset values, plus a hole in the map
    task automatic t_reset();
        rdchk(8'h9A, 8'h00);
        rdchk(8'h9B, 8'h00);
        rdchk(8'h9D, 8'h02);
        rdchk(8'h9F, 8'h00);
        rdchk(8'h9C, 8'h00);
        $display("reset test done");
    endtask
    // Spare bits, select codes 0 to 4 and 7, every hysteresis and response code
    task automatic t_access();
        int c;
        wr(8'h9B, 8'hFF);
        wr(8'h9A, 8'hFF);
        wr(8'h9D, 8'hFF);
        wr(8'h9F, 8'hFF);
        waitn(1);
        chk({3'h0, cfg0}, 8'h1F);
        chk({3'h0, cfg1}, 8'h1F);
        chk(pos_pin, 8'hFF);
        rdchk(8'h9B, 8'hBF);
        rdchk(8'h9A, 8'hBF);
        rdchk(8'h9D, 8'h33);
        rdchk(8'h9F, 8'h77);
        wr(8'h9B, 8'h00);
        rdchk(8'h9B, 8'h00);
        for (c = 0; c < 5; c++)
        begin
            wr(8'h9F, {1'b0, c[2:0], 1'b0, c[2:0]});
            wr(8'h9D, {6'h00, c[1:0]});
            wr(8'h9B, {4'h0, c[1:0], c[1:0]});
            chk(pos_pin, PIN32[c]);
            chk(neg_pin, PIN32[c + 5]);
            chk({6'h00, resp}, {6'h00, c[1:0]});
            chk({3'h0, cfg0}, {4'h0, c[1:0], c[1:0]});
        end
        $display("access test done");
    endtask
    // Edges, sticky flags, masking and the disabled output
    task automatic t_edges();
        wr(8'h9D, 8'h30);
        wr(8'h9B, 8'h80);
        waitn(8);
        chk(irq, 1'b0);
        rdchk(8'h9B, 8'h80);
        raw0 = 1'b1;
        waitn(8);
        chk(lat0, 1'b1);
        chk(irq, 1'b1);
        waitn(20);
        rdchk(8'h9B, 8'hE0);
        wr(8'h9B, 8'h80);
        waitn(1);
        chk(irq, 1'b0);
        wr(8'h9D, 8'h10);
        wr(8'h9B, 8'hA0);
        waitn(1);
        chk(irq, 1'b0);
        wr(8'h9B, 8'h80);
        raw0 = 1'b0;
        waitn(8);
        rdchk(8'h9B, 8'h90);
        chk(irq, 1'b1);
        wr(8'h9D, 8'h20);
        waitn(1);
        chk(irq, 1'b0);
        wr(8'h9B, 8'h00);
        raw0 = 1'b1;
        waitn(8);
        chk(lat0, 1'b0);
        rdchk(8'h9B, 8'h00);
        $display("edge test done");
    endtask
    // Second comparator keeps the same flags
    task automatic t_cmp1();
        wr(8'h9A, 8'h80);
        raw1 = 1'b1;
        waitn(8);
        chk(lat1, 1'b1);
        rdchk(8'h9A, 8'hE0);
        raw1 = 1'b0;
        waitn(8);
        rdchk(8'h9A, 8'hB0);
        // Clearing write lands on the very edge that sets the rise flag
        raw1 = 1'b1;
        waitn(2);
        wr(8'h9A, 8'h80);
        rdchk(8'h9A, 8'hE0);
        $display("cmp1 test done");
    endtask
    // Cuts a hang short; the tests need well under 1000 cycles
    initial
    begin
        #40000;
        num_errors++;
        summarize();
    end
    initial
    begin
        repeat (10) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        t_reset();
        t_access();
        t_edges();
        t_cmp1();
        summarize();
    end
endmodule
